// file: hdl/eeprom_link_cfg.svh
`ifndef EEPROM_LINK_CFG_SVH
`define EEPROM_LINK_CFG_SVH
`define CLK_PERIOD_NS 20
`define MEM_BYTES 512
`define ERASED_BYTE 8'hff
`define OP_SPECIAL 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define SUB_DISABLE 2'h0
`define SUB_FILL_ALL 2'h1
`define SUB_CLEAR_ALL 2'h2
`define SUB_ENABLE 2'h3
`define WORD_ADDR_LAST 5'h07
`define BYTE_ADDR_LAST 5'h08
`define WORD_DATA_LAST 5'h0f
`define BYTE_DATA_LAST 5'h07
`define WORD_CMD_BITS 5'h0b
`define BYTE_CMD_BITS 5'h0c
`define WORD_FRAME_BITS 5'h1b
`define BYTE_FRAME_BITS 5'h14
`define PROG_TIME_NS 5000000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define DESELECT_NS 250
`define DESELECT_CYCLES ((`DESELECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SK_HALF_NS 250
`define SK_HALF_CYCLES ((`SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SK_MAX_KHZ 2000
`define POWERUP_NS 1000000
`define POWERUP_CYCLES ((`POWERUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: hdl/eeprom_link_pkg.sv
package eeprom_link_pkg;
   typedef enum logic [2:0] {
      K_ENABLE = 3'h0,
      K_DISABLE = 3'h1,
      K_ERASE = 3'h2,
      K_WRITE = 3'h3,
      K_CLEAR_ALL = 3'h4,
      K_FILL_ALL = 3'h5
   } cmd_kind_t;

   typedef enum logic [2:0] {
      L_START = 3'h0,
      L_OPCODE = 3'h1,
      L_ADDR = 3'h2,
      L_DATA = 3'h3,
      L_READ = 3'h4,
      L_IGNORE = 3'h5
   } link_phase_t;

   typedef enum logic [2:0] {
      C_READ = 3'h0,
      C_WRITE = 3'h1,
      C_ERASE = 3'h2,
      C_ENABLE = 3'h3,
      C_DISABLE = 3'h4,
      C_CLEAR_ALL = 3'h5,
      C_FILL_ALL = 3'h6
   } host_cmd_t;

   typedef enum logic [2:0] {
      H_POWERUP = 3'h0,
      H_IDLE = 3'h1,
      H_SHIFT = 3'h2,
      H_DESEL = 3'h3,
      H_POLL = 3'h4,
      H_HUSH = 3'h5
   } host_state_t;

   typedef struct packed {
      link_phase_t phase;
      logic [4:0] cnt;
      logic [1:0] op;
      logic [8:0] addr;
      logic [15:0] data;
      logic [15:0] rd_sh;
      logic [8:0] rd_addr;
      logic rd_drive;
      logic rd_bit;
   } frame_st_t;

   typedef struct packed {
      logic cmd_tog;
      logic hush_tog;
      cmd_kind_t kind;
      logic [8:0] addr;
      logic [15:0] data;
   } arm_st_t;

   typedef struct packed {
      logic [26:0] bits;
      logic [4:0] len;
   } frame_t;
endpackage : eeprom_link_pkg

// file: hdl/eeprom_link_if.sv
`timescale 1ns/100ps
interface eeprom_link_if;
   logic chip_select;
   logic serial_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_en;
   modport device(input chip_select, input serial_clock, input serial_in,
                  output serial_out, output serial_out_en);
   modport host(output chip_select, output serial_clock, output serial_in,
                input serial_out, input serial_out_en);
endinterface : eeprom_link_if

// file: hdl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_st_t;
   sync_st_t s_r;
   sync_st_t s_nxt;

   if (W < 1) begin : g_chk
      $error("sync2 width must be at least one");
   end

   // first stage feeds only the second
   always_comb begin
      s_nxt.meta = d_i;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.stable;
endmodule : sync2

// file: hdl/eeprom_device.sv
`timescale 1ns/100ps
`include "eeprom_link_cfg.svh"
module eeprom_device
   import eeprom_link_pkg::*;
#(
   parameter int PROG_CYCLES = `PROG_CYCLES,
   parameter bit HAS_WIDTH_SELECT = 1'b1
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic width_select_i,
   eeprom_link_if.device link,
   output logic busy_o,
   output logic write_enabled_o
);
   localparam int TW = $clog2(PROG_CYCLES + 1);

   if (PROG_CYCLES < `MEM_BYTES || PROG_CYCLES > `PROG_CYCLES) begin : g_chk
      $error("program cycle count must cover the array and stay within 5 ms");
   end

   typedef struct packed {
      logic cs_d;
      logic tog_seen;
      logic hush_seen;
      logic width_select;
      logic wen;
      logic busy;
      logic status_show;
      cmd_kind_t kind;
      logic [8:0] addr;
      logic [15:0] data;
      logic [9:0] idx;
      logic [TW-1:0] timer;
      logic sout;
      logic sout_en;
   } core_st_t;

   logic [7:0] mem [0:`MEM_BYTES-1];

   frame_st_t fr_r;
   frame_st_t fr_nxt;
   arm_st_t arm_r;
   arm_st_t arm_nxt;
   core_st_t c_r;
   core_st_t c_nxt;
   logic frame_rst;
   logic org_link;
   logic [8:0] a_full;
   logic [8:0] rd_next;
   logic [4:0] addr_last;
   logic [4:0] data_last;
   logic [1:0] sub;
   logic [5:0] sync_d;
   logic [5:0] sync_q;
   logic cs_s;
   logic tog_s;
   logic hush_s;
   logic ws_s;
   logic drv_s;
   logic bit_s;
   logic fall;
   logic fill_all;
   logic [9:0] nbytes;
   logic [8:0] base;
   logic mem_we;
   logic [8:0] mem_a;
   logic [7:0] mem_d;

   // word read, byte mode left-aligned so the MSB is always bit 15
   function automatic logic [15:0] fetch(input logic [8:0] a, input logic width_select);
      if (width_select) begin
         fetch = {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
      end else begin
         fetch = {mem[a], `ERASED_BYTE};
      end
   endfunction : fetch

   // org is static; its synchronised copy is used as a quasi-static level here
   assign org_link = c_r.width_select;
   assign frame_rst = sys_rst_i | ~link.chip_select;

   // serial decoder, one step per rising serial_clock
   always_comb begin
      fr_nxt = fr_r;
      arm_nxt = arm_r;
      a_full = org_link ? {1'b0, fr_r.addr[6:0], link.serial_in}
                        : {fr_r.addr[7:0], link.serial_in};
      rd_next = org_link ? {1'b0, fr_r.rd_addr[7:0] + 8'h01} : fr_r.rd_addr + 9'h001;
      addr_last = org_link ? `WORD_ADDR_LAST : `BYTE_ADDR_LAST;
      data_last = org_link ? `WORD_DATA_LAST : `BYTE_DATA_LAST;
      sub = org_link ? a_full[7:6] : a_full[8:7];
      unique case (fr_r.phase)
         L_START: begin
            if (link.serial_in) begin
               fr_nxt.phase = L_OPCODE;
               fr_nxt.cnt = 5'h00;
               // any one here releases status output
               arm_nxt.hush_tog = ~arm_r.hush_tog;
            end
         end
         L_OPCODE: begin
            fr_nxt.op = {fr_r.op[0], link.serial_in};
            fr_nxt.cnt = fr_r.cnt + 5'h01;
            if (fr_r.cnt == 5'h01) begin
               fr_nxt.phase = L_ADDR;
               fr_nxt.cnt = 5'h00;
            end
         end
         L_ADDR: begin
            fr_nxt.addr = {fr_r.addr[7:0], link.serial_in};
            fr_nxt.cnt = fr_r.cnt + 5'h01;
            if (fr_r.cnt == addr_last) begin
               fr_nxt.addr = a_full;
               fr_nxt.cnt = 5'h00;
               fr_nxt.data = 16'h0000;
               fr_nxt.phase = L_IGNORE;
               unique case (fr_r.op)
                  `OP_READ: begin
                     fr_nxt.phase = L_READ;
                     fr_nxt.rd_addr = a_full;
                     fr_nxt.rd_sh = fetch(a_full, org_link);
                     fr_nxt.rd_drive = 1'b1;
                     fr_nxt.rd_bit = 1'b0;
                  end
                  `OP_ERASE: begin
                     arm_nxt.kind = K_ERASE;
                     arm_nxt.addr = a_full;
                     arm_nxt.cmd_tog = ~arm_r.cmd_tog;
                  end
                  `OP_WRITE: begin
                     fr_nxt.phase = L_DATA;
                  end
                  `OP_SPECIAL: begin
                     unique case (sub)
                        `SUB_ENABLE: arm_nxt.kind = K_ENABLE;
                        `SUB_DISABLE: arm_nxt.kind = K_DISABLE;
                        `SUB_CLEAR_ALL: arm_nxt.kind = K_CLEAR_ALL;
                        `SUB_FILL_ALL: fr_nxt.phase = L_DATA;
                     endcase
                     if (sub != `SUB_FILL_ALL) begin
                        arm_nxt.cmd_tog = ~arm_r.cmd_tog;
                     end
                  end
               endcase
            end
         end
         L_DATA: begin
            fr_nxt.data = {fr_r.data[14:0], link.serial_in};
            fr_nxt.cnt = fr_r.cnt + 5'h01;
            if (fr_r.cnt == data_last) begin
               fr_nxt.phase = L_IGNORE;
               arm_nxt.kind = (fr_r.op == `OP_WRITE) ? K_WRITE : K_FILL_ALL;
               arm_nxt.addr = fr_r.addr;
               arm_nxt.data = {fr_r.data[14:0], link.serial_in};
               arm_nxt.cmd_tog = ~arm_r.cmd_tog;
            end
         end
         L_READ: begin
            fr_nxt.rd_bit = fr_r.rd_sh[15];
            fr_nxt.rd_sh = {fr_r.rd_sh[14:0], 1'b0};
            fr_nxt.cnt = fr_r.cnt + 5'h01;
            if (fr_r.cnt == data_last) begin
               // next word follows with no dummy bit
               fr_nxt.cnt = 5'h00;
               fr_nxt.rd_addr = rd_next;
               fr_nxt.rd_sh = fetch(rd_next, org_link);
            end
         end
         L_IGNORE: begin
            fr_nxt.phase = L_IGNORE;
         end
         default: begin
            fr_nxt.phase = L_IGNORE;
         end
      endcase
   end

   always_ff @(posedge link.serial_clock or posedge frame_rst) begin
      if (frame_rst) begin
         fr_r <= '0;
      end else begin
         fr_r <= fr_nxt;
      end
   end

   // armed command survives deselect, guarded by its toggle
   always_ff @(posedge link.serial_clock or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         arm_r <= '0;
      end else begin
         arm_r <= arm_nxt;
      end
   end

   assign sync_d = {link.chip_select, arm_r.cmd_tog, arm_r.hush_tog, width_select_i,
                    fr_r.rd_drive, fr_r.rd_bit};

   sync2 #(.W(6)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .d_i(sync_d),
      .q_o(sync_q)
   );

   assign {cs_s, tog_s, hush_s, ws_s, drv_s, bit_s} = sync_q;
   assign fall = c_r.cs_d & ~cs_s;

   // self-timed core on the internal clock
   always_comb begin
      c_nxt = c_r;
      mem_we = 1'b0;
      mem_a = 9'h000;
      mem_d = 8'h00;
      fill_all = (c_r.kind == K_CLEAR_ALL) || (c_r.kind == K_FILL_ALL);
      nbytes = fill_all ? 10'(`MEM_BYTES) : (c_r.width_select ? 10'h002 : 10'h001);
      base = fill_all ? 9'h000 : (c_r.width_select ? {c_r.addr[7:0], 1'b0} : c_r.addr);
      c_nxt.cs_d = cs_s;
      c_nxt.width_select = HAS_WIDTH_SELECT ? ws_s : 1'b1;
      if (c_r.busy) begin
         if (c_r.idx < nbytes) begin
            mem_we = 1'b1;
            mem_a = base + c_r.idx[8:0];
            // new value replaces old, no erase needed
            if (c_r.kind == K_ERASE || c_r.kind == K_CLEAR_ALL) begin
               mem_d = `ERASED_BYTE;
            end else if (c_r.width_select && !c_r.idx[0]) begin
               mem_d = c_r.data[15:8];
            end else begin
               mem_d = c_r.data[7:0];
            end
            c_nxt.idx = c_r.idx + 10'h001;
         end
         if (c_r.timer == TW'(PROG_CYCLES - 1)) begin
            c_nxt.busy = 1'b0;
         end else begin
            c_nxt.timer = c_r.timer + TW'(1);
         end
      end
      if (hush_s != c_r.hush_seen) begin
         c_nxt.hush_seen = hush_s;
         if (cs_s) begin
            c_nxt.status_show = 1'b0;
         end
      end
      if (fall) begin
         c_nxt.tog_seen = tog_s;
         if (!c_r.busy) begin
            c_nxt.status_show = 1'b0;
         end
         if (tog_s != c_r.tog_seen && !c_r.busy) begin
            unique case (arm_r.kind)
               // latch set and cleared by command
               K_ENABLE: c_nxt.wen = 1'b1;
               K_DISABLE: c_nxt.wen = 1'b0;
               default: begin
                  if (c_r.wen) begin
                     // fill and clear share the sweep
                     c_nxt.busy = 1'b1;
                     c_nxt.status_show = 1'b1;
                     c_nxt.timer = '0;
                     c_nxt.idx = 10'h000;
                     c_nxt.kind = arm_r.kind;
                     c_nxt.addr = arm_r.addr;
                     c_nxt.data = arm_r.data;
                  end
               end
            endcase
         end
      end
      // drive only for read data or status
      c_nxt.sout_en = cs_s & (drv_s | c_nxt.status_show);
      // low while busy, high when ready
      c_nxt.sout = drv_s ? bit_s : ~c_nxt.busy;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   // nonvolatile array, deliberately not reset
   always_ff @(posedge clock_i) begin
      if (mem_we) begin
         mem[mem_a] <= mem_d;
      end
   end

   assign link.serial_out = c_r.sout;
   assign link.serial_out_en = c_r.sout_en;
   assign busy_o = c_r.busy;
   assign write_enabled_o = c_r.wen;
endmodule : eeprom_device

// file: hdl/eeprom_host.sv
`timescale 1ns/100ps
`include "eeprom_link_cfg.svh"
module eeprom_host
   import eeprom_link_pkg::*;
#(
   parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
   parameter int SK_HALF = `SK_HALF_CYCLES,
   parameter int DESELECT = `DESELECT_CYCLES
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic width_select_i,
   input wire logic cmd_valid_i,
   input wire host_cmd_t cmd_i,
   input wire logic [8:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic cmd_ready_o,
   output logic [15:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o,
   eeprom_link_if.host link
);
   localparam int PW = $clog2(POWERUP_CYCLES + 1);

   if (2 * SK_HALF * `CLK_PERIOD_NS < 1000000 / `SK_MAX_KHZ || SK_HALF > 255
       || DESELECT < `DESELECT_CYCLES || DESELECT > 255 || POWERUP_CYCLES < 1) begin : g_chk
      $error("host timing parameters out of range");
   end

   typedef struct packed {
      host_state_t st;
      logic [PW-1:0] pu;
      logic [7:0] div;
      logic cs;
      logic sk;
      logic di;
      logic [26:0] frame;
      logic [4:0] cnt;
      logic rd_phase;
      logic is_read;
      logic needs_poll;
      logic wen;
      logic [15:0] rdata;
      logic rvalid;
      logic done;
      logic ready;
   } host_st_t;

   host_st_t h_r;
   host_st_t h_nxt;
   frame_t fb;
   logic do_s;
   logic en_s;
   logic tick;

   function automatic frame_t build(input host_cmd_t c, input logic [8:0] a,
                                    input logic [15:0] d, input logic width_select);
      logic [1:0] op;
      logic [8:0] ad;
      logic has_data;
      op = `OP_SPECIAL;
      ad = a;
      has_data = 1'b0;
      unique case (c)
         C_READ: op = `OP_READ;
         C_WRITE: begin
            op = `OP_WRITE;
            has_data = 1'b1;
         end
         C_ERASE: op = `OP_ERASE;
         C_ENABLE: ad = width_select ? {1'b0, `SUB_ENABLE, 6'h00} : {`SUB_ENABLE, 7'h00};
         C_DISABLE: ad = width_select ? {1'b0, `SUB_DISABLE, 6'h00} : {`SUB_DISABLE, 7'h00};
         C_CLEAR_ALL: ad = width_select ? {1'b0, `SUB_CLEAR_ALL, 6'h00} : {`SUB_CLEAR_ALL, 7'h00};
         default: begin
            ad = width_select ? {1'b0, `SUB_FILL_ALL, 6'h00} : {`SUB_FILL_ALL, 7'h00};
            has_data = 1'b1;
         end
      endcase
      if (width_select) begin
         build.bits = {1'b1, op, ad[7:0], d};
         build.len = has_data ? `WORD_FRAME_BITS : `WORD_CMD_BITS;
      end else begin
         build.bits = {1'b1, op, ad, d[7:0], 7'h00};
         build.len = has_data ? `BYTE_FRAME_BITS : `BYTE_CMD_BITS;
      end
   endfunction : build

   sync2 #(.W(2)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .d_i({link.serial_out, link.serial_out_en}),
      .q_o({do_s, en_s})
   );

   assign tick = (h_r.div == 8'(SK_HALF - 1));
   assign fb = build(cmd_i, addr_i, wdata_i, width_select_i);

   // command sequencer, serial_clock made by dividing clock_i
   always_comb begin
      h_nxt = h_r;
      h_nxt.rvalid = 1'b0;
      h_nxt.done = 1'b0;
      unique case (h_r.st)
         H_POWERUP: begin
            h_nxt.pu = h_r.pu + PW'(1);
            if (h_r.pu == PW'(POWERUP_CYCLES - 1)) begin
               h_nxt.st = H_IDLE;
            end
         end
         H_IDLE: begin
            if (cmd_valid_i) begin
               h_nxt.st = H_SHIFT;
               h_nxt.cs = 1'b1;
               h_nxt.sk = 1'b0;
               h_nxt.div = 8'h00;
               h_nxt.frame = fb.bits;
               h_nxt.di = fb.bits[26];
               h_nxt.cnt = fb.len - 5'h01;
               h_nxt.rd_phase = 1'b0;
               h_nxt.rdata = 16'h0000;
               h_nxt.is_read = (cmd_i == C_READ);
               // a disabled device shows no status, so skip polling
               h_nxt.needs_poll = h_r.wen && (cmd_i == C_WRITE || cmd_i == C_ERASE
                                  || cmd_i == C_CLEAR_ALL || cmd_i == C_FILL_ALL);
               if (cmd_i == C_ENABLE) begin
                  h_nxt.wen = 1'b1;
               end else if (cmd_i == C_DISABLE) begin
                  h_nxt.wen = 1'b0;
               end
            end
         end
         H_SHIFT: begin
            h_nxt.div = tick ? 8'h00 : h_r.div + 8'h01;
            if (tick && !h_r.sk) begin
               h_nxt.sk = 1'b1;
            end else if (tick) begin
               h_nxt.sk = 1'b0;
               if (!h_r.rd_phase && h_r.cnt != 5'h00) begin
                  h_nxt.frame = {h_r.frame[25:0], 1'b0};
                  h_nxt.di = h_r.frame[25];
                  h_nxt.cnt = h_r.cnt - 5'h01;
               end else if (!h_r.rd_phase && h_r.is_read) begin
                  h_nxt.rd_phase = 1'b1;
                  h_nxt.di = 1'b0;
                  h_nxt.cnt = width_select_i ? `WORD_DATA_LAST : `BYTE_DATA_LAST;
               end else if (h_r.rd_phase && h_r.cnt != 5'h00) begin
                  h_nxt.rdata = {h_r.rdata[14:0], do_s};
                  h_nxt.cnt = h_r.cnt - 5'h01;
               end else begin
                  h_nxt.rdata = h_r.rd_phase ? {h_r.rdata[14:0], do_s} : h_r.rdata;
                  h_nxt.rvalid = h_r.rd_phase;
                  h_nxt.cs = 1'b0;
                  h_nxt.di = 1'b0;
                  h_nxt.st = H_DESEL;
               end
            end
         end
         H_DESEL: begin
            // hold deselect at least the minimum
            h_nxt.div = h_r.div + 8'h01;
            if (h_r.div == 8'(DESELECT - 1)) begin
               h_nxt.div = 8'h00;
               if (h_r.needs_poll) begin
                  h_nxt.needs_poll = 1'b0;
                  h_nxt.cs = 1'b1;
                  h_nxt.st = H_POLL;
               end else begin
                  h_nxt.done = 1'b1;
                  h_nxt.st = H_IDLE;
               end
            end
         end
         H_POLL: begin
            if (h_r.div != 8'(DESELECT - 1)) begin
               h_nxt.div = h_r.div + 8'h01;
            end else if (en_s && do_s) begin
               h_nxt.div = 8'h00;
               h_nxt.di = 1'b1;
               h_nxt.st = H_HUSH;
            end
         end
         H_HUSH: begin
            // dummy one floats the status output
            h_nxt.div = tick ? 8'h00 : h_r.div + 8'h01;
            if (tick && !h_r.sk) begin
               h_nxt.sk = 1'b1;
            end else if (tick) begin
               h_nxt.sk = 1'b0;
               h_nxt.cs = 1'b0;
               h_nxt.di = 1'b0;
               h_nxt.st = H_DESEL;
            end
         end
         default: begin
            h_nxt.st = H_IDLE;
         end
      endcase
      h_nxt.ready = (h_nxt.st == H_IDLE);
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign link.chip_select = h_r.cs;
   assign link.serial_clock = h_r.sk;
   assign link.serial_in = h_r.di;
   assign cmd_ready_o = h_r.ready;
   assign rdata_o = h_r.rdata;
   assign rdata_valid_o = h_r.rvalid;
   assign done_o = h_r.done;
endmodule : eeprom_host

// file: tb/eeprom_link_assertions.sv
`timescale 1ns/100ps
module eeprom_link_assertions (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en
);
   logic sk_q;
   logic [7:0] run_r, low_r;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // run lengths saturate so long idles never wrap
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {sk_q, run_r, low_r} <= '0;
      end else begin
         sk_q <= serial_clock;
         run_r <= (serial_clock != sk_q) ? 8'h00 : run_r + {7'h00, ~&run_r};
         low_r <= chip_select ? 8'h00 : low_r + {7'h00, ~&low_r};
      end
   end
   chk_out_float: assert property (!chip_select [*6] |-> !serial_out_en)
      else $error("output not released");
   chk_en_quiet: assert property ($rose(chip_select) |-> !serial_out_en)
      else $error("output on at select");
   chk_in_hold: assert property ($rose(serial_clock) |=> $stable(serial_in) [*8])
      else $error("input moved after rise");
   chk_sk_framed: assert property (serial_clock |-> chip_select)
      else $error("clock while deselected");
   chk_sk_rate: assert property ($changed(serial_clock) |-> run_r >= 8'h0c)
      else $error("clock half too short");
   chk_gap_min: assert property ($rose(chip_select) |-> low_r >= 8'h0d)
      else $error("deselect too short");
   chk_lead_zero: assert property ($rose(serial_out_en) |-> !serial_out)
      else $error("first output not zero");
   chk_ready_seen: assert property ($fell(serial_out_en) && chip_select |-> $past(serial_out))
      else $error("released before ready");
   cover property ($rose(serial_out_en));
   cover property ($fell(serial_out_en) && chip_select);
   cover property ($rose(chip_select));
endmodule : eeprom_link_assertions

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
   import eeprom_link_pkg::*;
;
   localparam logic [8:0] A = 9'h05a;
   localparam logic [15:0] D1 = 16'hc35a, D2 = 16'h3ca5;
   logic clock_i = 1'b0, sys_rst_i = 1'b1, ws = 1'b1, cmd_valid_i = 1'b0;
   logic cmd_ready_o, done_o, we_o, busy_o, rv_o;
   host_cmd_t cmd_i = C_READ;
   logic [8:0] addr_i = 9'h000;
   logic [15:0] wdata_i = 16'h0000, rdata_o;
   int n_mismatch = 0, checks = 0, cyc = 0, n_busy = 0, n_rv = 0;
   eeprom_link_if link();
   eeprom_device #(.PROG_CYCLES(600)) u_eeprom_device (.clock_i, .sys_rst_i,
      .width_select_i(ws), .link, .busy_o, .write_enabled_o(we_o));
   eeprom_host #(.POWERUP_CYCLES(20)) u_eeprom_host (.clock_i, .sys_rst_i,
      .width_select_i(ws), .cmd_valid_i, .cmd_i, .addr_i, .wdata_i, .cmd_ready_o,
      .rdata_o, .rdata_valid_o(rv_o), .done_o, .link);
   eeprom_link_assertions u_eeprom_link_assertions (.clock_i, .sys_rst_i,
      .chip_select(link.chip_select), .serial_clock(link.serial_clock),
      .serial_in(link.serial_in), .serial_out(link.serial_out),
      .serial_out_en(link.serial_out_en));
   // byte mode compares the low byte only
   task automatic check(input string what, input logic [15:0] exp, got);
      checks++;
      if (((got ^ exp) & (ws ? 16'hffff : 16'h00ff)) !== 16'h0000) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : check
   // request held until taken, then wait for done
   task automatic op(input host_cmd_t c, logic [8:0] a, logic [15:0] d);
      cmd_i = c;
      addr_i = a;
      wdata_i = d;
      cmd_valid_i = 1'b1;
      while (cmd_ready_o !== 1'b1) @(negedge clock_i);
      @(negedge clock_i);
      cmd_valid_i = 1'b0;
      while (done_o !== 1'b1) @(negedge clock_i);
      @(negedge clock_i);
   endtask : op
   // each read must also raise exactly one data strobe
   task automatic rd(input string what, logic [8:0] a, logic [15:0] exp);
      int n;
      n = n_rv;
      op(C_READ, a, '0);
      check(what, exp, rdata_o);
      check("strobe", 16'(n + 1), 16'(n_rv));
   endtask : rd
   // launched program cycles and read strobes, counted for later checks
   always @(posedge busy_o) n_busy++;
   always @(posedge rv_o) n_rv++;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   // clock
   initial begin
      forever #10 clock_i = ~clock_i;
   end
   // hang guard, well above both passes
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_mismatch++;
         finish_test;
      end
   end
   // word pass then byte pass, strap changed only in reset
   initial begin
      for (int m = 0; m < 2; m++) begin
         ws = (m == 0);
         sys_rst_i = 1'b1;
         repeat (10) @(negedge clock_i);
         sys_rst_i = 1'b0;
         check("latch", '0, {15'h0000, we_o});
         op(C_ENABLE, '0, '0);
         check("latch", 16'h0001, {15'h0000, we_o});
         op(C_CLEAR_ALL, '0, '0);
         op(C_DISABLE, '0, '0);
         check("latch", '0, {15'h0000, we_o});
         op(C_WRITE, A, D1);
         check("cycles", 16'(5 * m + 1), 16'(n_busy));
         rd("locked", A, 16'hffff);
         op(C_ENABLE, '0, '0);
         op(C_WRITE, A, D1);
         op(C_ERASE, A, '0);
         rd("erase", A, 16'hffff);
         op(C_FILL_ALL, '0, D2);
         op(C_WRITE, A, D1);
         rd("fill", ws ? 9'h0ff : 9'h1ff, D2);
         rd("over", A, D1);
         check("cycles", 16'(5 * m + 5), 16'(n_busy));
         check("busy", '0, {15'h0000, busy_o});
         $display("test %0d done", m);
      end
      finish_test;
   end
endmodule : testbench
